// file: adcs_pkg.sv
package adcs_pkg;

	// Register offsets on the 8-bit register port
	localparam logic [7:0] OFS_PORT_A_DATA = 8'h05;
	localparam logic [7:0] OFS_PORT_E_DATA = 8'h09;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] OFS_PERIPHERAL_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_CONV_RESULT_HIGH = 8'h1E;
	localparam logic [7:0] OFS_CONV_CONTROL_MAIN = 8'h1F;
	localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] OFS_PORT_E_DIRECTION_PARALLEL = 8'h89;
	localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLES = 8'h8C;
	localparam logic [7:0] OFS_CONV_RESULT_LOW = 8'h9E;
	localparam logic [7:0] OFS_CONV_PIN_FORMAT_CONFIG = 8'h9F;

	// Reset values
	localparam logic [7:0] RST_CONV_CONTROL_MAIN = 8'h00;
	localparam logic [7:0] RST_CONV_PIN_FORMAT_CONFIG = 8'h00;
	localparam logic [7:0] RST_PORT_A_DIRECTION = 8'h3F;
	localparam logic [7:0] RST_PORT_E_DIRECTION = 8'h07;
	localparam logic [7:0] RST_IRQ_REG = 8'h00;

	// Implemented bits of each register; the rest read as zero
	localparam logic [7:0] MASK_PORT_A = 8'h3F;
	localparam logic [7:0] MASK_PORT_E_DIR = 8'h17;
	localparam logic [7:0] MASK_IRQ_BANK = 8'hF7;
	localparam logic [7:0] MASK_CTRL_MAIN = 8'hFD;
	localparam logic [7:0] MASK_CTRL_FORMAT = 8'h8F;

	// Field positions
	localparam int BIT_CONV_DONE_FLAG = 6;
	localparam int BIT_CONV_DONE_IRQ_ENABLE = 6;

	// Conversion clock select encodings
	localparam logic [1:0] CS_OSC2 = 2'b00;
	localparam logic [1:0] CS_OSC8 = 2'b01;
	localparam logic [1:0] CS_OSC32 = 2'b10;
	localparam logic [1:0] CS_RC = 2'b11;

	// Timing; the system clock stands in for the oscillator
	localparam int CNT_W = 16;
	localparam int CLK_PERIOD_NS = 8;
	localparam int INSTR_CYCLE_OSC = 4;
	localparam int BP_OSC2 = 2;
	localparam int BP_OSC8 = 8;
	localparam int BP_OSC32 = 32;
	localparam int RC_BP_TYP_NS = 4000;
	localparam int RC_BP_CYC = RC_BP_TYP_NS / CLK_PERIOD_NS;
	localparam int CONV_BPS = 12;
	localparam int HOLD_BPS = 2;
	localparam int RES_BITS = 10;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

	// Analog pin map per pin config code, bit n = channel n is analog
	localparam logic [15:0][7:0] ANALOG_MAP = {
		8'h0D, 8'h01, 8'h0F, 8'h1F, 8'h3F, 8'h3F, 8'h3F, 8'hFF,
		8'h00, 8'h00, 8'h0B, 8'h0B, 8'h1F, 8'h1F, 8'hFF, 8'hFF};

	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_ACQ = 5'b00010,
		ST_START = 5'b00100,
		ST_CONV = 5'b01000,
		ST_HOLD = 5'b10000
	} adcs_state_type;

	typedef struct packed {
		logic [1:0] conv_clock_select;
		logic [2:0] channel_select;
		logic go;
		logic unused;
		logic converter_power_on;
	} adcs_ctrl_main_type;

	typedef struct packed {
		logic result_justify_select;
		logic [2:0] unused;
		logic [3:0] analog_pin_config;
	} adcs_ctrl_format_type;

endpackage

// file: adcs_sequencer.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

//Contract
// R1: A conversion spans at least twelve conversion bit periods.
// R2: Bit period selectable as 2, 8, 32 oscillator periods or internal RC.
// R3: Clock select 00=2, 01=8, 10=32 periods, 11=RC source.
// R4: Software keeps the bit period at or above 1.6 microseconds.
// R5: RC bit period is typically 4 microseconds, range 2 to 6.
// R6: Above 1 MHz software uses RC clock only for sleep conversions.
// R7: Port reads return zero on pins configured as analog.
// R8: Conversion runs regardless of channel and direction settings.
// R9: Clearing trigger mid-conversion aborts; result pair keeps its old value.
// R10: After abort wait two bit periods, then acquire again automatically.
// R11: First segment after trigger lasts one instruction cycle up to one bit period.
// R12: Software does not set trigger in the same write that powers on.
// R13: Result justified left or right by format bit, unused bits zero.
// R14: With converter off, result bytes are plain read/write storage.
// R15: With RC clock, wait one instruction cycle before converting.
// R16: Sleep completion clears trigger, loads result, wakes or powers down.
// R17: Sleep with non-RC clock aborts and powers down, enable kept.
// R18: Reset turns converter off, aborts, resets registers, pins analog.
// R19: Power-on reset leaves result pair untouched and unknown.
// R20: Completion loads result, clears trigger, sets done flag.
// R21: After completion wait two bit periods disconnected before acquiring.
// R22: Successive approximation, one bit per bit period, MSB first.
module adcs_sequencer #(
	parameter int RC_BP_CYC = adcs_pkg::RC_BP_CYC
) (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [7:0] RDATA,
	input wire logic SLEEP_MODE,
	input wire logic [5:0] PORT_A_PINS,
	input wire logic [2:0] PORT_E_PINS,
	input wire logic CMP_HIGH,
	output logic [9:0] DAC_CODE,
	output logic SAMPLE_ON,
	output logic CONV_POWER,
	output logic [2:0] CHANNEL_SEL,
	output logic [7:0] ANALOG_MASK,
	output logic [5:0] PIN_DIR_A,
	output logic [2:0] PIN_DIR_E,
	output logic CONV_DONE_FLAG,
	output logic WAKE_REQ
);

	adcs_pkg::adcs_state_type state_q, state_d;
	adcs_pkg::adcs_ctrl_main_type ctrl_main_q;
	adcs_pkg::adcs_ctrl_format_type ctrl_fmt_q;
	logic [7:0] irq_ctrl_q, pir_q, pie_q, dir_a_q, dir_e_q;
	logic [7:0] res_high_q, res_low_q, rdata_q, analog_q;
	logic [9:0] sar_q;
	logic [adcs_pkg::CNT_W-1:0] seg_cnt_q, seg_len, bp_len;
	logic [3:0] bp_idx_q;
	logic [3:0] bit_pos;
	logic pwr_down_q, sample_q, power_q, wake_q;
	logic enabled, rc_sel, seg_done, state_change, complete, sleep_abort;
	logic wr_main, wr_high, wr_low;
	logic [15:0] res_just;

	// Bus write decode
	// Port data writes are ignored: the pins belong to the port block,
	// this block only masks what software reads back
	assign wr_main = WR_STB && (ADDR == adcs_pkg::OFS_CONV_CONTROL_MAIN);
	assign wr_high = WR_STB && (ADDR == adcs_pkg::OFS_CONV_RESULT_HIGH);
	assign wr_low = WR_STB && (ADDR == adcs_pkg::OFS_CONV_RESULT_LOW);

	assign rc_sel = (ctrl_main_q.conv_clock_select == adcs_pkg::CS_RC);
	// Powered only while enabled and not shut down by sleep
	// Sleep power-down leaves the enable bit set, so software sees no change
	// and the converter resumes once the core wakes
	assign enabled = ctrl_main_q.converter_power_on && !pwr_down_q;

	// Bit period length in system clocks
	// The system clock stands in for the oscillator. The RC choice uses a
	// parameter, since its period is not tied to the system clock; keep it
	// near the typical period for real use, smaller only to speed up tests
	always_comb begin
		case (ctrl_main_q.conv_clock_select) // see R2
			adcs_pkg::CS_OSC2: bp_len = adcs_pkg::CNT_W'(adcs_pkg::BP_OSC2); // see R3
			adcs_pkg::CS_OSC8: bp_len = adcs_pkg::CNT_W'(adcs_pkg::BP_OSC8); // see R3
			adcs_pkg::CS_OSC32: bp_len = adcs_pkg::CNT_W'(adcs_pkg::BP_OSC32); // see R3
			default: bp_len = adcs_pkg::CNT_W'(RC_BP_CYC); // see R3 R5
		endcase
	end

	// Segment length; the first segment is one instruction cycle, stretched to
	// a non-RC bit period where that is longer. With 2-period clocks the instruction
	// cycle is the longer one, so the minimum wins over the maximum there.
	always_comb begin
		seg_len = bp_len;
		if (state_q == adcs_pkg::ST_START) begin
			if (rc_sel || bp_len < adcs_pkg::CNT_W'(adcs_pkg::INSTR_CYCLE_OSC)) begin
				seg_len = adcs_pkg::CNT_W'(adcs_pkg::INSTR_CYCLE_OSC); // see R11 R15
			end
		end
	end

	assign seg_done = (seg_cnt_q >= seg_len - adcs_pkg::CNT_W'(1));
	assign state_change = (state_d != state_q);

	// Normal completion: last bit period of the conversion ends
	assign complete = (state_q == adcs_pkg::ST_CONV) && enabled && ctrl_main_q.go && seg_done
		&& (bp_idx_q == 4'(adcs_pkg::CONV_BPS - 1)); // see R1

	// A non-RC conversion cannot survive sleep
	assign sleep_abort = SLEEP_MODE && ctrl_main_q.converter_power_on && !rc_sel; // see R17

	// Sequencer next state
	// OFF -> ACQ on enable; ACQ -> START on trigger; START holds the first
	// segment; CONV counts twelve bit periods; HOLD keeps the cap off two bit
	// periods after a completion or abort, then acquisition restarts.
	// Losing the enable from any state drops straight to OFF.
	always_comb begin
		state_d = state_q;
		case (state_q)
			adcs_pkg::ST_OFF: begin
				if (enabled) begin
					state_d = adcs_pkg::ST_ACQ;
				end
			end
			adcs_pkg::ST_ACQ: begin
				if (!enabled) begin
					state_d = adcs_pkg::ST_OFF;
				end else if (ctrl_main_q.go) begin
					state_d = adcs_pkg::ST_START;
				end
			end
			adcs_pkg::ST_START: begin
				if (!enabled) begin
					state_d = adcs_pkg::ST_OFF;
				end else if (!ctrl_main_q.go) begin
					state_d = adcs_pkg::ST_HOLD; // see R9 R10
				end else if (seg_done) begin
					state_d = adcs_pkg::ST_CONV; // see R11 R15
				end
			end
			adcs_pkg::ST_CONV: begin
				if (!enabled) begin
					state_d = adcs_pkg::ST_OFF; // see R17
				end else if (!ctrl_main_q.go || complete) begin
					state_d = adcs_pkg::ST_HOLD; // see R9 R21
				end
			end
			adcs_pkg::ST_HOLD: begin
				if (!enabled) begin
					state_d = adcs_pkg::ST_OFF;
				end else if (seg_done && bp_idx_q == 4'(adcs_pkg::HOLD_BPS - 1)) begin
					state_d = adcs_pkg::ST_ACQ; // see R10 R21
				end
			end
			default: state_d = adcs_pkg::ST_OFF;
		endcase
	end

	// State register; reset leaves the converter off
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= adcs_pkg::ST_OFF; // see R18
		end else begin
			state_q <= state_d;
		end
	end

	// Cycle counter within a segment and bit period index
	// Both restart on every state change, so each state counts from zero
	// and a clock select change mid-state at worst ends the segment early
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			seg_cnt_q <= '0;
			bp_idx_q <= '0;
		end else if (state_change) begin
			seg_cnt_q <= '0;
			bp_idx_q <= '0;
		end else if (seg_done) begin
			seg_cnt_q <= '0;
			bp_idx_q <= bp_idx_q + 4'(1);
		end else begin
			seg_cnt_q <= seg_cnt_q + adcs_pkg::CNT_W'(1);
		end
	end

	// Bit decided at the end of bit period k, k = 1..10
	assign bit_pos = 4'(adcs_pkg::RES_BITS) - bp_idx_q;

	// Successive approximation register, MSB first; the comparator input is
	// taken whatever the pin direction, so an output pin converts its level
	// Each decision takes the comparator at the end of its bit period, so the
	// comparator sees the trial code settle for a whole period
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			sar_q <= '0;
		end else if (state_d == adcs_pkg::ST_CONV && state_q != adcs_pkg::ST_CONV) begin
			sar_q <= adcs_pkg::SAR_FIRST_TRIAL; // see R22
		end else if (state_q == adcs_pkg::ST_CONV && seg_done && bp_idx_q >= 4'(1)
			&& bp_idx_q <= 4'(adcs_pkg::RES_BITS)) begin
			sar_q[bit_pos] <= CMP_HIGH; // see R8 R22
			if (bit_pos != 4'(0)) begin
				sar_q[bit_pos - 4'(1)] <= 1'b1; // see R22
			end
		end
	end

	// Justified result, unused bits zero
	always_comb begin
		if (ctrl_fmt_q.result_justify_select) begin
			res_just = {6'h00, sar_q}; // see R13
		end else begin
			res_just = {sar_q, 6'h00}; // see R13
		end
	end

	// Result pair has no reset, so any reset leaves it as it was; while the
	// converter is off nothing loads it and it is plain storage
	// Trade-off: a software write in the completion cycle is lost, as the
	// finished result is worth more than a write racing it
	always_ff @(posedge CLK_SYS) begin
		if (complete) begin
			res_high_q <= res_just[15:8]; // see R20 R16
			res_low_q <= res_just[7:0]; // see R20 R16
		end else begin
			if (wr_high) begin
				res_high_q <= WDATA; // see R14 R19
			end
			if (wr_low) begin
				res_low_q <= WDATA; // see R14 R19
			end
		end
	end

	// Main control register; trigger cleared by completion or sleep abort,
	// and ignored when the same write powers the converter on
	// A write in the completion cycle wins over the hardware clear, so a
	// trigger that software sets there starts the next conversion
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_main_q <= adcs_pkg::RST_CONV_CONTROL_MAIN; // see R18
		end else begin
			if (complete || sleep_abort) begin
				ctrl_main_q.go <= 1'b0; // see R20 R16 R17
			end
			if (wr_main) begin
				ctrl_main_q <= WDATA & adcs_pkg::MASK_CTRL_MAIN;
				ctrl_main_q.go <= WDATA[2] && WDATA[0] && ctrl_main_q.converter_power_on; // see R12
			end
		end
	end

	// Format and pin configuration, direction registers
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_fmt_q <= adcs_pkg::RST_CONV_PIN_FORMAT_CONFIG; // see R18
			dir_a_q <= adcs_pkg::RST_PORT_A_DIRECTION; // see R18
			dir_e_q <= adcs_pkg::RST_PORT_E_DIRECTION; // see R18
		end else if (WR_STB) begin
			if (ADDR == adcs_pkg::OFS_CONV_PIN_FORMAT_CONFIG) begin
				ctrl_fmt_q <= WDATA & adcs_pkg::MASK_CTRL_FORMAT;
			end else if (ADDR == adcs_pkg::OFS_PORT_A_DIRECTION) begin
				dir_a_q <= WDATA & adcs_pkg::MASK_PORT_A;
			end else if (ADDR == adcs_pkg::OFS_PORT_E_DIRECTION_PARALLEL) begin
				dir_e_q <= WDATA & adcs_pkg::MASK_PORT_E_DIR;
			end
		end
	end

	// Interrupt registers; completion beats a clearing write in the same cycle
	// Interrupt control is stored only; waking the core is decided here from
	// the enable and flag bits, the rest of the interrupt logic lives elsewhere
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_ctrl_q <= adcs_pkg::RST_IRQ_REG;
			pir_q <= adcs_pkg::RST_IRQ_REG;
			pie_q <= adcs_pkg::RST_IRQ_REG;
		end else begin
			if (WR_STB && ADDR == adcs_pkg::OFS_INTERRUPT_CONTROL) begin
				irq_ctrl_q <= WDATA;
			end
			if (WR_STB && ADDR == adcs_pkg::OFS_PERIPHERAL_IRQ_ENABLES) begin
				pie_q <= WDATA & adcs_pkg::MASK_IRQ_BANK;
			end
			if (WR_STB && ADDR == adcs_pkg::OFS_PERIPHERAL_IRQ_FLAGS) begin
				pir_q <= WDATA & adcs_pkg::MASK_IRQ_BANK;
			end
			if (complete) begin
				pir_q[adcs_pkg::BIT_CONV_DONE_FLAG] <= 1'b1; // see R20
			end
		end
	end

	// Sleep power-down; enable bit stays set, released when sleep ends
	// The power-down holds the sequencer in OFF; once it clears,
	// acquisition starts without the two bit period wait
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			pwr_down_q <= 1'b0;
		end else if (!SLEEP_MODE) begin
			pwr_down_q <= 1'b0;
		end else if (sleep_abort) begin
			pwr_down_q <= 1'b1; // see R17
		end else if (complete && !pie_q[adcs_pkg::BIT_CONV_DONE_IRQ_ENABLE]) begin
			pwr_down_q <= 1'b1; // see R16
		end
	end

	// Registered outputs toward the analog front end and the core
	// Sample and power come from the next state; mask and wake lag one cycle, accepted so that every
	// output of the block comes from a flip-flop
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			sample_q <= 1'b0;
			power_q <= 1'b0;
			wake_q <= 1'b0;
			analog_q <= 8'hFF; // see R18
		end else begin
			sample_q <= (state_d == adcs_pkg::ST_ACQ); // see R21
			power_q <= (state_d != adcs_pkg::ST_OFF);
			wake_q <= SLEEP_MODE && pie_q[adcs_pkg::BIT_CONV_DONE_IRQ_ENABLE]
				&& (pir_q[adcs_pkg::BIT_CONV_DONE_FLAG] || complete); // see R16
			analog_q <= adcs_pkg::ANALOG_MAP[ctrl_fmt_q.analog_pin_config];
		end
	end

	// Read data stands for one cycle after the strobe, zero otherwise
	// Zero outside the read slot lets several blocks share one read bus
	// with a plain OR
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= 8'h00;
		end else if (!RD_STB) begin
			rdata_q <= 8'h00;
		end else if (ADDR == adcs_pkg::OFS_PORT_A_DATA) begin
			rdata_q <= {2'b00, PORT_A_PINS & ~{analog_q[4], 1'b0, analog_q[3:0]}}; // see R7
		end else if (ADDR == adcs_pkg::OFS_PORT_E_DATA) begin
			rdata_q <= {5'h00, PORT_E_PINS & ~analog_q[7:5]}; // see R7
		end else if (ADDR == adcs_pkg::OFS_INTERRUPT_CONTROL) begin
			rdata_q <= irq_ctrl_q;
		end else if (ADDR == adcs_pkg::OFS_PERIPHERAL_IRQ_FLAGS) begin
			rdata_q <= pir_q;
		end else if (ADDR == adcs_pkg::OFS_CONV_RESULT_HIGH) begin
			rdata_q <= res_high_q;
		end else if (ADDR == adcs_pkg::OFS_CONV_CONTROL_MAIN) begin
			rdata_q <= ctrl_main_q;
		end else if (ADDR == adcs_pkg::OFS_PORT_A_DIRECTION) begin
			rdata_q <= dir_a_q;
		end else if (ADDR == adcs_pkg::OFS_PORT_E_DIRECTION_PARALLEL) begin
			rdata_q <= dir_e_q;
		end else if (ADDR == adcs_pkg::OFS_PERIPHERAL_IRQ_ENABLES) begin
			rdata_q <= pie_q;
		end else if (ADDR == adcs_pkg::OFS_CONV_RESULT_LOW) begin
			rdata_q <= res_low_q;
		end else if (ADDR == adcs_pkg::OFS_CONV_PIN_FORMAT_CONFIG) begin
			rdata_q <= ctrl_fmt_q;
		end else begin
			rdata_q <= 8'h00; // Unmapped
		end
	end

	// Outputs, all straight from flip-flops
	assign RDATA = rdata_q;
	assign DAC_CODE = sar_q;
	assign SAMPLE_ON = sample_q;
	assign CONV_POWER = power_q;
	assign CHANNEL_SEL = ctrl_main_q.channel_select;
	assign ANALOG_MASK = analog_q;
	assign PIN_DIR_A = dir_a_q[5:0];
	assign PIN_DIR_E = dir_e_q[2:0];
	assign CONV_DONE_FLAG = pir_q[adcs_pkg::BIT_CONV_DONE_FLAG];
	assign WAKE_REQ = wake_q;

endmodule

// file: adcs_sequencer_chk.sv
`timescale 1ns/1ps
module adcs_sequencer_chk (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [7:0] RDATA,
	input wire logic SLEEP_MODE,
	input wire logic SAMPLE_ON,
	input wire logic CONV_POWER,
	input wire logic [7:0] ANALOG_MASK,
	input wire logic CONV_DONE_FLAG
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	logic [7:0] low_cnt_q;
	// Cycles with the holding cap off; saturates so long idle spells cannot wrap
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) low_cnt_q <= 8'h00;
		else if (SAMPLE_ON) low_cnt_q <= 8'h00;
		else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
	end
	// Hardware completion, not a software write of the flag register
	sequence s_done;
		$rose(CONV_DONE_FLAG) && !($past(WR_STB) && $past(ADDR) == 8'h0C);
	endsequence
	sequence s_fmt(logic [3:0] c);
		WR_STB && ADDR == 8'h9F && WDATA[3:0] == c;
	endsequence
	sequence s_no_fmt;
		!(WR_STB && ADDR == 8'h9F);
	endsequence
	property p_mask(logic [3:0] c, logic [7:0] m);
		s_fmt(c) ##1 s_no_fmt ##1 s_no_fmt |-> ANALOG_MASK == m;
	endproperty
	a_rdata_idle: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
		else $error("read data not zero outside read slot");
	a_unmapped_zero: assert property ($past(RD_STB) && !($past(ADDR) inside {8'h05, 8'h09,
		8'h0B, 8'h0C, 8'h1E, 8'h1F, 8'h85, 8'h89, 8'h8C, 8'h9E, 8'h9F}) |-> RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_bit_one: assert property ($past(RD_STB) && $past(ADDR) == 8'h1F |-> !RDATA[1])
		else $error("unimplemented control bit reads one");
	a_port_analog_zero: assert property ($past(RD_STB) && $past(ADDR) == 8'h05 |->
		(RDATA[3:0] & ANALOG_MASK[3:0]) == 4'h0 && !(RDATA[5] && ANALOG_MASK[4]))
		else $error("analog pin reads one");
	a_mask_all_an: assert property (p_mask(4'h0, 8'hFF))
		else $error("all analog config not applied");
	a_mask_all_dig: assert property (p_mask(4'h6, 8'h00))
		else $error("all digital config not applied");
	a_conv_min_len: assert property (s_done |-> low_cnt_q >= 8'd24)
		else $error("conversion shorter than twelve bit periods");
	a_hold_after_done: assert property (s_done |-> !SAMPLE_ON [*4])
		else $error("acquire restarted too soon");
	a_power_up: assert property (WR_STB && ADDR == 8'h1F && WDATA[0] && !SLEEP_MODE
		|-> ##[1:3] CONV_POWER) else $error("converter did not power up");
endmodule

// file: adcs_sequencer_tb_top.sv
`timescale 1ns/1ps
module adcs_sequencer_tb_top;
	logic clk, arst_n, wr, rd, sleep, cmp, pend;
	logic [7:0] addr, wdata, rdata, amask;
	logic [5:0] pa, dir_a;
	logic [2:0] pe, dir_e, chs;
	logic [9:0] dac, target;
	logic samp, pwr, flag, wake;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 5;
	int cycles = 0;
	int c;
	adcs_sequencer #(.RC_BP_CYC(8)) uut (.CLK_SYS(clk), .ARST_N(arst_n), .ADDR(addr),
		.WDATA(wdata), .WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .SLEEP_MODE(sleep),
		.PORT_A_PINS(pa), .PORT_E_PINS(pe), .CMP_HIGH(cmp), .DAC_CODE(dac),
		.SAMPLE_ON(samp), .CONV_POWER(pwr), .CHANNEL_SEL(chs), .ANALOG_MASK(amask),
		.PIN_DIR_A(dir_a), .PIN_DIR_E(dir_e), .CONV_DONE_FLAG(flag), .WAKE_REQ(wake));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp1(input logic g, input logic e);
		cmp8({7'h00, g}, {7'h00, e});
	endtask
	task automatic cmp_rng(input int g, input int lo, input int hi);
		samples_checked++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h..%h", $time, g, lo, hi);
		end
	endtask
	task automatic conclude;
		$display("checked %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Bounded wait: 0 = sample switch, 1 = done flag, 2 = power
	task automatic wait_sig(input int s, input logic v, output int n);
		n = 0;
		while ((s == 0 ? samp : s == 1 ? flag : pwr) !== v && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) cmp1(1'b0, 1'b1);
	endtask
	task automatic convert(input logic [1:0] cs, input logic [2:0] ch, input logic rj);
		int bp;
		bp = (cs == 2'b01 || cs == 2'b11) ? 8 : (cs == 2'b10) ? 32 : 2;
		target = 10'($random(seed));
		wr_reg(8'h9F, {rj, 7'h00});
		wr_reg(8'h1F, {cs, ch, 3'h1});
		wait_sig(0, 1'b1, c);
		wr_reg(8'h1F, {cs, ch, 3'h5});
		wait_sig(1, 1'b1, c);
		cmp_rng(c, 12 * bp, 13 * bp + 8);
		cmp8(dac[9:2], target[9:2]);
		cmp8({6'h00, dac[1:0]}, {6'h00, target[1:0]});
		cmp8({5'h00, chs}, {5'h00, ch});
		rd_reg(8'h1F, {cs, ch, 3'h1});
		rd_reg(8'h0C, 8'h40);
		rd_reg(8'h1E, rj ? {6'h00, target[9:8]} : target[9:2]);
		rd_reg(8'h9E, rj ? target[7:0] : {target[1:0], 6'h00});
		wr_reg(8'h0C, 8'h00);
	endtask
	// Comparator model: the input sits at target, judged against the trial code
	always @(posedge clk) begin
		cmp <= (target >= dac);
	end
	// Read data stands only in the cycle after the strobe, so compare it there
	always @(posedge clk) begin
		if (pend) cmp8(rdata, exp_q.pop_front());
		pend <= rd;
	end
	// Ceiling well above the longest sequence, so a hang still ends the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("timeout");
			conclude();
		end
	end
	initial begin
		{arst_n, wr, rd, sleep, pend, addr, wdata, target} = '0;
		pa = 6'($random(seed));
		pe = 3'($random(seed));
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		rd_reg(8'h1F, 8'h00);
		rd_reg(8'h85, 8'h3F);
		rd_reg(8'h89, 8'h07);
		rd_reg(8'h40, 8'h00);
		rd_reg(8'h05, {3'h0, pa[4], 4'h0});
		wr_reg(8'h1F, 8'h05);
		rd_reg(8'h1F, 8'h01);
		$display("registers done");
		for (int i = 0; i < 8; i++) convert(2'(i), 3'(i), i[0]);
		$display("conversions done");
		wr_reg(8'h1F, 8'h45);
		repeat (20) @(posedge clk);
		wr_reg(8'h1E, 8'hA5);
		wr_reg(8'h1F, 8'h41);
		wait_sig(0, 1'b1, c);
		cmp_rng(c, 16, 26);
		cmp1(flag, 1'b0);
		rd_reg(8'h1E, 8'hA5);
		wr_reg(8'h1F, 8'h05);
		repeat (8) @(posedge clk);
		sleep <= 1'b1;
		wait_sig(2, 1'b0, c);
		cmp_rng(c, 0, 4);
		rd_reg(8'h1F, 8'h01);
		sleep <= 1'b0;
		wr_reg(8'h8C, 8'h40);
		wr_reg(8'h1F, 8'hC1);
		wait_sig(0, 1'b1, c);
		wr_reg(8'h1F, 8'hC5);
		sleep <= 1'b1;
		wait_sig(1, 1'b1, c);
		@(posedge clk);
		cmp1(wake, 1'b1);
		sleep <= 1'b0;
		rd_reg(8'h1F, 8'hC1);
		$display("abort and sleep done");
		wr_reg(8'h1F, 8'h00);
		wr_reg(8'h9F, 8'h06);
		wr_reg(8'h9E, 8'h3C);
		wr_reg(8'h85, 8'h15);
		wr_reg(8'h89, 8'h02);
		rd_reg(8'h9E, 8'h3C);
		rd_reg(8'h05, {2'h0, pa});
		rd_reg(8'h09, {5'h00, pe});
		cmp8({2'h0, dir_a}, 8'h15);
		cmp8({5'h00, dir_e}, 8'h02);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		cmp8(amask, 8'hFF);
		cmp1(pwr, 1'b0);
		cmp8({2'h0, dir_a}, 8'h3F);
		cmp8({5'h00, dir_e}, 8'h07);
		cmp8({5'h00, chs}, 8'h00);
		rd_reg(8'h9E, 8'h3C);
		rd_reg(8'h9F, 8'h00);
		rd_reg(8'h8C, 8'h00);
		rd_reg(8'h0C, 8'h00);
		repeat (3) @(posedge clk);
		$display("reset done");
		conclude();
	end
endmodule
bind adcs_sequencer adcs_sequencer_chk chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .SLEEP_MODE(SLEEP_MODE),
	.SAMPLE_ON(SAMPLE_ON), .CONV_POWER(CONV_POWER), .ANALOG_MASK(ANALOG_MASK),
	.CONV_DONE_FLAG(CONV_DONE_FLAG));
